// File: rcc_top.sv
// Two-channel position capture control with an AHB-Lite register slave.
// Assumes encoder positions and the update strobe are synchronous to hclk.
// Function
// - Configuring a channel discards all its captured results.
// - Configure is refused on an enabled channel; nothing changes.
// - Each channel keeps its own source, units and mode.
// - No capture happens until enable has succeeded.
// - Manual modes feed event readout; automated modes feed frame readout.
// - Source select 0 takes reference encoder, 1 takes feedback encoder.
// - Encoder locations coded 0 to 4; 4 is host-supplied position.
// - Positive units setting scales to units per rev, rounded to nearest.
// - Setting 0 to -16 gives two to (32 plus setting) units per rev.
// - Format 0 includes turns over the full signed 32-bit range.
// - Format 1 strips turns from reported positions.
// - Non power of two units with turns gives warning status 2.
// - Mode codes 1 to 7 pick pulse or edge polarity, manual or automated.
// - Channel index 0 or 1 uses the digital input of that number.
// - Successful enable flushes captured data before capture begins.
// - Enable is rejected unless the channel was configured validly.
// - Enable on an enabled channel returns -15 and changes nothing.
// - Disable stops capture; on a disabled channel returns -19.
//
// Our own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module rcc_top
  import rcc_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Position sources and capture inputs
  input wire logic pos_update,
  input wire logic [1:0] dig_in,
  input wire logic [3:0][31:0] enc_turns,
  input wire logic [3:0][31:0] enc_angle
);
  import rcc_pkg::*;

  logic acc;
  logic wr_q;
  logic [7:0] addr_q;
  logic [31:0] hrdata_q;
  logic [31:0] cfg_q;
  logic [31:0] units_q;
  logic [31:0] result_q;
  logic [2:0] ref_loc_q;
  logic [2:0] fb_loc_q;
  logic [31:0] href_q;
  logic [31:0] hfb_q;
  logic [1:0] src_q [2];
  logic [31:0] unit_q [2];
  logic fmt_q [2];
  logic [2:0] mode_q [2];
  rcc_state_type state_q [2];
  logic [1:0] prev_q;
  logic [1:0] inp_q;
  logic [31:0] start_q [2];
  logic [31:0] evt_pos_q [2];
  logic [31:0] evt_wid_q [2];
  logic [31:0] frm_pos_q [2];
  logic [31:0] frm_wid_q [2];
  logic [1:0] evt_vld_q;
  logic [1:0] frm_vld_q;
  logic [31:0] pos [2];
  logic cmd_go;
  rcc_op_type op;
  logic [3:0] cmd_ch;
  logic chn;
  logic args_ok;
  logic [31:0] result_d;
  logic [1:0] cfg_set;
  logic [1:0] clr;
  logic [1:0] en_set;
  logic [1:0] dis_set;
  logic [31:0] rd_d;
  logic [1:0] rclr_evt;
  logic [1:0] rclr_frm;

  // Scale a raw position to reported units
  function automatic logic [31:0] scale_pos(input logic [31:0] turns,
    input logic [31:0] angle, input logic [31:0] units, input logic fmt);
    logic [63:0] prod;
    logic [31:0] frac;
    logic [63:0] full;
    logic [4:0] sh;
    prod = {32'h0, angle} * {32'h0, units};
    frac = 32'((prod + ROUND_HALF) >> 32);
    full = {turns, angle};
    sh = 5'(-$signed(units));
    if ($signed(units) > 0)
    begin
      if (fmt)
        scale_pos = (frac == units) ? 32'h0 : frac;
      else
        scale_pos = 32'(turns * units) + frac;
    end
    else if (fmt)
      scale_pos = 32'($signed(angle) >>> sh);
    else
      scale_pos = 32'($signed(full) >>> sh);
  endfunction

  // True for pulse modes, manual or automated
  function automatic logic is_pulse(input logic [2:0] m);
    is_pulse = (m >= MODE_FIRST) && (m <= MODE_LAST_PULSE);
  endfunction

  // True when the mode delivers through the frame path
  function automatic logic is_auto(input logic [2:0] m);
    is_auto = (m == MODE_AUTO_NEG) || (m == MODE_AUTO_POS);
  endfunction

  // Zero-wait slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign acc = hsel && hready && htrans[1];

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q <= 1'b0;
      addr_q <= 8'h00;
    end
    else
    begin
      wr_q <= acc && hwrite;
      addr_q <= haddr[7:0];
    end
  end

  // Source mux per channel
  always_comb
  begin
    logic [2:0] loc;
    logic [31:0] hp;
    loc = 3'h0;
    hp = 32'h0;
    for (int c = 0; c < 2; c++)
    begin
      loc = src_q[c][0] ? fb_loc_q : ref_loc_q;
      hp = src_q[c][0] ? hfb_q : href_q;
      if (loc == LOC_HOST)
        pos[c] = scale_pos({{16{hp[31]}}, hp[31:HOST_TURN_LSB]},
                           {hp[HOST_TURN_LSB-1:0], 16'h0}, unit_q[c], fmt_q[c]);
      else
        pos[c] = scale_pos(enc_turns[loc[1:0]], enc_angle[loc[1:0]],
                           unit_q[c], fmt_q[c]);
    end
  end

  // Request decode and result code
  always_comb
  begin
    logic [2:0] m;
    logic [31:0] u;
    m = cfg_q[CFG_MODE_LSB +: 3];
    u = units_q;
    cmd_go = wr_q && (addr_q == CMD_OFS);
    op = rcc_op_type'(hwdata[CMD_OP_LSB +: 2]);
    cmd_ch = hwdata[CMD_CH_LSB +: 4];
    chn = cmd_ch[0];
    args_ok = (cfg_q[CFG_SRC_LSB +: 2] < 2'h2) && (cfg_q[CFG_FMT_LSB +: 2] < 2'h2)
      && (m >= MODE_FIRST) && ($signed(u) >= UNITS_MIN);
    result_d = result_q;
    cfg_set = 2'b00;
    en_set = 2'b00;
    dis_set = 2'b00;
    if (cmd_go && op != OP_NONE)
    begin
      if (cmd_ch > 4'h1)
        result_d = ST_BAD_CHAN;
      else if (op == OP_CONFIG)
      begin
        if (state_q[chn] == CH_ARMED)
          result_d = ST_BUSY;
        else if (!args_ok)
          result_d = ST_BAD_ARG;
        else
        begin
          cfg_set[chn] = 1'b1;
          if ($signed(u) > 0 && (u & (u - 32'h1)) != 32'h0
              && cfg_q[CFG_FMT_LSB +: 2] == 2'h0)
            result_d = ST_WARN;
          else
            result_d = ST_OK;
        end
      end
      else if (op == OP_ENABLE)
      begin
        if (state_q[chn] == CH_ARMED)
          result_d = ST_ALREADY_ON;
        else if (state_q[chn] == CH_IDLE)
          result_d = ST_NOT_CFG;
        else
        begin
          en_set[chn] = 1'b1;
          result_d = ST_OK;
        end
      end
      else if (state_q[chn] != CH_ARMED)
        result_d = ST_ALREADY_OFF;
      else
      begin
        dis_set[chn] = 1'b1;
        result_d = ST_OK;
      end
    end
    clr = cfg_set | en_set;
  end

  // Software registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg_q <= CFG_RST;
      units_q <= UNITS_RST;
      ref_loc_q <= LOC_RST;
      fb_loc_q <= LOC_RST;
      href_q <= HPOS_RST;
      hfb_q <= HPOS_RST;
      result_q <= ST_OK;
    end
    else
    begin
      result_q <= result_d;
      if (wr_q)
      begin
        case (addr_q)
          CFG_OFS: cfg_q <= hwdata;
          UNITS_OFS: units_q <= hwdata;
          HREF_OFS: href_q <= hwdata;
          HFB_OFS: hfb_q <= hwdata;
          LOC_OFS:
          begin
            // Locations above the host code are ignored
            if (hwdata[LOC_REF_LSB +: 3] <= LOC_HOST)
              ref_loc_q <= hwdata[LOC_REF_LSB +: 3];
            if (hwdata[LOC_FB_LSB +: 3] <= LOC_HOST)
              fb_loc_q <= hwdata[LOC_FB_LSB +: 3];
          end
          default: ;
        endcase
      end
    end
  end

  // Per-channel settings and state
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int c = 0; c < 2; c++)
      begin
        src_q[c] <= 2'h0;
        unit_q[c] <= UNITS_RST;
        fmt_q[c] <= 1'b0;
        mode_q[c] <= 3'h0;
        state_q[c] <= CH_IDLE;
      end
    end
    else
    begin
      for (int c = 0; c < 2; c++)
      begin
        if (cfg_set[c])
        begin
          // Own copy per channel
          src_q[c] <= cfg_q[CFG_SRC_LSB +: 2];
          unit_q[c] <= units_q;
          fmt_q[c] <= cfg_q[CFG_FMT_LSB];
          mode_q[c] <= cfg_q[CFG_MODE_LSB +: 3];
        end
        case (state_q[c])
          CH_IDLE: if (cfg_set[c]) state_q[c] <= CH_READY;
          CH_READY: if (en_set[c]) state_q[c] <= CH_ARMED;
          CH_ARMED: if (dis_set[c]) state_q[c] <= CH_READY;
          default: state_q[c] <= CH_IDLE;
        endcase
      end
    end
  end

  // Capture on update cycles; set beats read clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prev_q <= 2'b00;
      inp_q <= 2'b00;
      evt_vld_q <= 2'b00;
      frm_vld_q <= 2'b00;
      for (int c = 0; c < 2; c++)
      begin
        start_q[c] <= 32'h0;
        evt_pos_q[c] <= 32'h0;
        evt_wid_q[c] <= 32'h0;
        frm_pos_q[c] <= 32'h0;
        frm_wid_q[c] <= 32'h0;
      end
    end
    else
    begin
      for (int c = 0; c < 2; c++)
      begin
        logic rise;
        logic fall;
        logic lead;
        logic trail;
        logic hit;
        rise = dig_in[c] && !prev_q[c];
        fall = !dig_in[c] && prev_q[c];
        lead = mode_q[c][0] ? fall : rise;
        trail = mode_q[c][0] ? rise : fall;
        hit = (mode_q[c] == MODE_BOTH_EDGE) ? (rise || fall)
          : (mode_q[c] == MODE_POS_EDGE) ? rise
          : (mode_q[c] == MODE_NEG_EDGE) ? fall : 1'b0;
        if (pos_update)
          prev_q[c] <= dig_in[c];
        if (rclr_evt[c])
          evt_vld_q[c] <= 1'b0;
        if (rclr_frm[c])
          frm_vld_q[c] <= 1'b0;
        if (clr[c])
        begin
          // Flush flags and the stored start so no stale width survives
          evt_vld_q[c] <= 1'b0;
          frm_vld_q[c] <= 1'b0;
          inp_q[c] <= 1'b0;
          start_q[c] <= 32'h0;
        end
        else if (pos_update && state_q[c] == CH_ARMED)
        begin
          if (is_pulse(mode_q[c]))
          begin
            if (lead)
            begin
              start_q[c] <= pos[c];
              inp_q[c] <= 1'b1;
            end
            else if (trail && inp_q[c])
            begin
              inp_q[c] <= 1'b0;
              if (is_auto(mode_q[c]))
              begin
                frm_pos_q[c] <= start_q[c];
                frm_wid_q[c] <= pos[c] - start_q[c];
                frm_vld_q[c] <= 1'b1;
              end
              else
              begin
                evt_pos_q[c] <= start_q[c];
                evt_wid_q[c] <= pos[c] - start_q[c];
                evt_vld_q[c] <= 1'b1;
              end
            end
          end
          else if (hit)
          begin
            evt_pos_q[c] <= pos[c];
            evt_wid_q[c] <= pos[c] - start_q[c];
            start_q[c] <= pos[c];
            evt_vld_q[c] <= 1'b1;
          end
        end
      end
    end
  end

  // Read mux and read-clear of result valid flags
  always_comb
  begin
    logic [7:0] a;
    a = haddr[7:0];
    rd_d = 32'h0;
    rclr_evt = 2'b00;
    rclr_frm = 2'b00;
    for (int c = 0; c < 2; c++)
    begin
      if (a == EVT_POS_OFS + 8'(c) * CH_STRIDE)
      begin
        rd_d = evt_pos_q[c];
        rclr_evt[c] = acc && !hwrite;
      end
      if (a == EVT_WID_OFS + 8'(c) * CH_STRIDE)
        rd_d = evt_wid_q[c];
      if (a == FRM_POS_OFS + 8'(c) * CH_STRIDE)
      begin
        rd_d = frm_pos_q[c];
        rclr_frm[c] = acc && !hwrite;
      end
      if (a == FRM_WID_OFS + 8'(c) * CH_STRIDE)
        rd_d = frm_wid_q[c];
    end
    case (a)
      CFG_OFS: rd_d = cfg_q;
      UNITS_OFS: rd_d = units_q;
      RESULT_OFS: rd_d = result_q;
      CHSTAT_OFS: rd_d = {26'h0, state_q[1], state_q[0]};
      LOC_OFS: rd_d = {25'h0, fb_loc_q, 1'b0, ref_loc_q};
      HREF_OFS: rd_d = href_q;
      HFB_OFS: rd_d = hfb_q;
      CAPSTAT_OFS: rd_d = {28'h0, frm_vld_q, evt_vld_q};
      default: ;
    endcase
  end

  // Read data registered at the address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_q <= 32'h0;
    else if (acc && !hwrite)
      hrdata_q <= rd_d;
  end

  // Checks
  sequence cfg_req_s;
    cmd_go && op == OP_CONFIG && cmd_ch <= 4'h1;
  endsequence
  sequence en_req_s;
    cmd_go && op == OP_ENABLE && cmd_ch <= 4'h1;
  endsequence

  cfg_refused_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg_req_s and (state_q[chn] == CH_ARMED) |=> result_q == ST_BUSY
      && $stable(unit_q[0]) && $stable(unit_q[1])
      && $stable(mode_q[0]) && $stable(mode_q[1]))
    else $error("configure on enabled channel not refused");
  cfg_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg_req_s and (state_q[chn] != CH_ARMED) and args_ok |=>
      !evt_vld_q[$past(chn)] && !frm_vld_q[$past(chn)])
    else $error("configure left captured data");
  no_capture_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q[0] != CH_ARMED |=> !$rose(evt_vld_q[0]) && !$rose(frm_vld_q[0]))
    else $error("capture while not enabled");
  en_flush_a: assert property (@(posedge hclk) disable iff (!hresetn)
    en_req_s and (state_q[chn] == CH_READY) |=> state_q[$past(chn)] == CH_ARMED
      && !evt_vld_q[$past(chn)] ##1 1)
    else $error("enable did not flush");
  en_reject_a: assert property (@(posedge hclk) disable iff (!hresetn)
    en_req_s and (state_q[chn] == CH_IDLE) |=> result_q == ST_NOT_CFG
      && state_q[$past(chn)] == CH_IDLE)
    else $error("enable of unconfigured channel accepted");
  en_again_a: assert property (@(posedge hclk) disable iff (!hresetn)
    en_req_s and (state_q[chn] == CH_ARMED) |=> result_q == ST_ALREADY_ON
      && state_q[$past(chn)] == CH_ARMED)
    else $error("repeat enable not reported");
  dis_again_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_go && op == OP_DISABLE && cmd_ch <= 4'h1 && state_q[chn] != CH_ARMED
      |=> result_q == ST_ALREADY_OFF)
    else $error("repeat disable not reported");
  bad_chan_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_go && op != OP_NONE && cmd_ch > 4'h1 |=> result_q == ST_BAD_CHAN
      && $stable(state_q[0]) && $stable(state_q[1]))
    else $error("bad channel not reported");
  units_warn_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg_req_s and (result_d == ST_WARN) |=> state_q[$past(chn)] != CH_IDLE)
    else $error("warned configure not accepted");
endmodule
`default_nettype wire

// File: rcc_pkg.sv
// Constants for the two-channel position capture block: register map,
// field positions, status codes, mode codes and channel states.
// Assumes a 32-bit AHB-Lite register bus and word-aligned registers.
package rcc_pkg;
  // Register byte offsets
  localparam logic [7:0] CMD_OFS = 8'h00;
  localparam logic [7:0] CFG_OFS = 8'h04;
  localparam logic [7:0] UNITS_OFS = 8'h08;
  localparam logic [7:0] RESULT_OFS = 8'h0C;
  localparam logic [7:0] CHSTAT_OFS = 8'h10;
  localparam logic [7:0] LOC_OFS = 8'h14;
  localparam logic [7:0] HREF_OFS = 8'h18;
  localparam logic [7:0] HFB_OFS = 8'h1C;
  localparam logic [7:0] CAPSTAT_OFS = 8'h20;
  localparam logic [7:0] EVT_POS_OFS = 8'h30;
  localparam logic [7:0] EVT_WID_OFS = 8'h38;
  localparam logic [7:0] FRM_POS_OFS = 8'h40;
  localparam logic [7:0] FRM_WID_OFS = 8'h48;
  localparam logic [7:0] CH_STRIDE = 8'h04;
  // Field positions
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_CH_LSB = 4;
  localparam int CFG_SRC_LSB = 0;
  localparam int CFG_FMT_LSB = 4;
  localparam int CFG_MODE_LSB = 8;
  localparam int LOC_REF_LSB = 0;
  localparam int LOC_FB_LSB = 4;
  localparam int HOST_TURN_LSB = 16;
  // Reset values
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [31:0] UNITS_RST = 32'h0000_0000;
  localparam logic [2:0] LOC_RST = 3'h0;
  localparam logic [31:0] HPOS_RST = 32'h0000_0000;
  // Status codes
  localparam logic [31:0] ST_OK = 32'h0000_0000;
  localparam logic [31:0] ST_WARN = 32'h0000_0002;
  localparam logic [31:0] ST_BAD_CHAN = 32'hFFFF_FFFF;
  localparam logic [31:0] ST_BAD_ARG = 32'hFFFF_FFFE;
  localparam logic [31:0] ST_BUSY = 32'hFFFF_FFFD;
  localparam logic [31:0] ST_NOT_CFG = 32'hFFFF_FFFC;
  localparam logic [31:0] ST_ALREADY_ON = 32'hFFFF_FFF1;
  localparam logic [31:0] ST_ALREADY_OFF = 32'hFFFF_FFED;
  // Argument limits and codes
  localparam logic signed [31:0] UNITS_MIN = -32'sd16;
  localparam logic [2:0] LOC_HOST = 3'h4;
  localparam logic [2:0] MODE_FIRST = 3'h1;
  localparam logic [2:0] MODE_LAST_PULSE = 3'h4;
  localparam logic [2:0] MODE_AUTO_NEG = 3'h3;
  localparam logic [2:0] MODE_AUTO_POS = 3'h4;
  localparam logic [2:0] MODE_NEG_EDGE = 3'h5;
  localparam logic [2:0] MODE_POS_EDGE = 3'h6;
  localparam logic [2:0] MODE_BOTH_EDGE = 3'h7;
  localparam logic [63:0] ROUND_HALF = 64'h0000_0000_8000_0000;
  // Request codes
  typedef enum logic [1:0] {
    OP_NONE = 2'h0,
    OP_CONFIG = 2'h1,
    OP_ENABLE = 2'h2,
    OP_DISABLE = 2'h3
  } rcc_op_type;
  // Channel states, one-hot
  typedef enum logic [2:0] {
    CH_IDLE = 3'b001,
    CH_READY = 3'b010,
    CH_ARMED = 3'b100
  } rcc_state_type;
endpackage

// File: rcc_enc_model.sv
// Encoder position source model for the capture control bench.
// Assumes step_req comes from the bench, synchronous to hclk.
`timescale 1ns/1ps
`default_nettype none
module rcc_enc_model
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bench control
  input wire logic step_req,
  // Position outputs
  output logic pos_update,
  output logic [3:0][31:0] enc_turns,
  output logic [3:0][31:0] enc_angle
);
  logic [31:0] upd_cnt_q;
  // One-cycle update strobe for each bench request
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pos_update <= 1'b0;
    else
      pos_update <= step_req;
  end
  // Updates seen so far; advances after each strobe
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      upd_cnt_q <= 32'h0000_0000;
    else if (pos_update)
      upd_cnt_q <= upd_cnt_q + 32'h0000_0001;
  end
  // A sixteenth turn per update; location l runs l turns ahead
  always_comb
  begin
    for (int l = 0; l < 4; l++)
    begin
      enc_turns[l] = (upd_cnt_q >> 4) + 32'(l);
      enc_angle[l] = {upd_cnt_q[3:0], 28'h000_0000};
    end
  end
endmodule
`default_nettype wire

// File: test_registration_capture_channel_control.sv
// Self-checking bench for the two-channel capture control block.
// Assumes the zero-wait AHB-Lite slave in rcc_top and rcc_enc_model.
`timescale 1ns/1ps
`default_nettype none
module test_registration_capture_channel_control;
  import rcc_pkg::*;
  localparam int LIMIT = 4000;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, step_req, pos_update;
  logic [31:0] haddr, hwdata, hrdata, upd_k, k1, pexp;
  logic [1:0] htrans, dig_in;
  logic [3:0][31:0] enc_turns, enc_angle;
  int miscompares, num_checks, cyc;
  // Design and encoder sources
  rcc_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .pos_update(pos_update), .dig_in(dig_in), .enc_turns(enc_turns),
    .enc_angle(enc_angle));
  rcc_enc_model enc (.hclk(hclk), .hresetn(hresetn), .step_req(step_req),
    .pos_update(pos_update), .enc_turns(enc_turns), .enc_angle(enc_angle));
  // Clock
  always #20 hclk = ~hclk;
  // Closing report
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Hang guard
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      miscompares = miscompares + 1;
      give_verdict();
    end
  end
  // Compare one value
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp)
    begin
      miscompares = miscompares + 1;
      $display("[ERR] %0t: read %h expected %h", $time, seen, exp);
    end
  endtask
  // One single AHB-Lite transfer, address phase then data phase
  task automatic bus(input logic is_wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= is_wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= is_wr ? d : 32'h0000_0000;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(q, exp);
    chk({31'h0000_0000, hresp}, 32'h0000_0000);
  endtask
  // Issue a request and check its status
  task automatic op(input rcc_op_type o, input logic [3:0] ch, input logic [31:0] exp);
    wr(CMD_OFS, {24'h00_0000, ch, 2'h0, o});
    rdchk(RESULT_OFS, exp);
  endtask
  task automatic cfg(input logic [3:0] ch, input logic [1:0] src, input logic [1:0] fmt,
    input logic [2:0] mode, input logic [31:0] units, input logic [31:0] exp);
    wr(CFG_OFS, {21'h00_0000, mode, 2'h0, fmt, 2'h0, src});
    wr(UNITS_OFS, units);
    op(OP_CONFIG, ch, exp);
  endtask
  // One position update with the given capture input levels
  task automatic upd(input logic [1:0] d);
    @(posedge hclk);
    dig_in <= d;
    step_req <= 1'b1;
    @(posedge hclk);
    step_req <= 1'b0;
    repeat (2) @(posedge hclk);
    upd_k = upd_k + 32'h0000_0001;
  endtask
  task automatic endt(input string name);
    $display("test %s finished", name);
  endtask
  // Main sequence
  initial
  begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    step_req = 1'b0;
    dig_in = 2'h0;
    upd_k = 32'h0000_0000;
    miscompares = 0;
    num_checks = 0;
    cyc = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk(CHSTAT_OFS, 32'h0000_0009);
    rdchk(RESULT_OFS, ST_OK);
    rdchk(8'hFC, 32'h0000_0000);
    op(OP_ENABLE, 4'h0, ST_NOT_CFG);
    cfg(4'h2, 2'h0, 2'h0, 3'h2, 32'h0000_0010, ST_BAD_CHAN);
    cfg(4'h0, 2'h0, 2'h0, 3'h0, 32'h0000_0010, ST_BAD_ARG);
    cfg(4'h0, 2'h0, 2'h0, 3'h2, 32'hFFFF_FFEF, ST_BAD_ARG);
    endt("arguments");
    wr(LOC_OFS, 32'h0000_0020);
    rdchk(LOC_OFS, 32'h0000_0020);
    for (int m = 7; m >= 1; m--)
      cfg(4'h0, 2'h0, 2'h0, 3'(m), 32'h0000_0010, ST_OK);
    cfg(4'h0, 2'h0, 2'h0, 3'h2, 32'h0000_0010, ST_OK);
    rdchk(CHSTAT_OFS, 32'h0000_000A);
    upd(2'h0);
    upd(2'h1);
    upd(2'h0);
    rdchk(CAPSTAT_OFS, 32'h0000_0000);
    op(OP_ENABLE, 4'h0, ST_OK);
    op(OP_ENABLE, 4'h0, ST_ALREADY_ON);
    rdchk(CHSTAT_OFS, 32'h0000_000C);
    cfg(4'h0, 2'h0, 2'h0, 3'h1, 32'h0000_0010, ST_BUSY);
    rdchk(CHSTAT_OFS, 32'h0000_000C);
    endt("configure and enable");
    upd(2'h0);
    k1 = upd_k;
    upd(2'h1);
    upd(2'h1);
    upd(2'h0);
    rdchk(CAPSTAT_OFS, 32'h0000_0001);
    rdchk(EVT_WID_OFS, 32'h0000_0002);
    rdchk(EVT_POS_OFS, k1);
    rdchk(CAPSTAT_OFS, 32'h0000_0000);
    upd(2'h1);
    upd(2'h0);
    rdchk(CAPSTAT_OFS, 32'h0000_0001);
    op(OP_DISABLE, 4'h0, ST_OK);
    op(OP_DISABLE, 4'h0, ST_ALREADY_OFF);
    op(OP_ENABLE, 4'h0, ST_OK);
    rdchk(CAPSTAT_OFS, 32'h0000_0000);
    op(OP_DISABLE, 4'h0, ST_OK);
    upd(2'h1);
    upd(2'h0);
    rdchk(CAPSTAT_OFS, 32'h0000_0000);
    endt("manual pulse");
    cfg(4'h1, 2'h1, 2'h0, 3'h4, 32'hFFFF_FFF0, ST_OK);
    op(OP_ENABLE, 4'h1, ST_OK);
    upd(2'h0);
    k1 = upd_k;
    upd(2'h2);
    upd(2'h0);
    rdchk(CAPSTAT_OFS, 32'h0000_0008);
    pexp = (((k1 >> 4) + 32'h0000_0002) << 16) | {16'h0000, k1[3:0], 12'h000};
    rdchk(FRM_POS_OFS + CH_STRIDE, pexp);
    upd(2'h2);
    upd(2'h0);
    op(OP_DISABLE, 4'h1, ST_OK);
    cfg(4'h1, 2'h1, 2'h0, 3'h4, 32'hFFFF_FFF0, ST_OK);
    rdchk(CAPSTAT_OFS, 32'h0000_0000);
    endt("automated pulse");
    cfg(4'h0, 2'h0, 2'h0, 3'h6, 32'h0000_0168, ST_WARN);
    cfg(4'h0, 2'h0, 2'h1, 3'h6, 32'h0000_0168, ST_OK);
    op(OP_ENABLE, 4'h0, ST_OK);
    upd(2'h0);
    k1 = upd_k;
    upd(2'h1);
    pexp = ({28'h000_0000, k1[3:0]} * 32'h0000_002D + 32'h0000_0001) >> 1;
    rdchk(EVT_POS_OFS, pexp);
    endt("full scale");
    op(OP_DISABLE, 4'h0, ST_OK);
    wr(LOC_OFS, 32'h0000_0024);
    cfg(4'h0, 2'h0, 2'h0, 3'h5, 32'hFFFF_FFF0, ST_OK);
    op(OP_ENABLE, 4'h0, ST_OK);
    wr(HREF_OFS, 32'h0003_1234);
    upd(2'h1);
    wr(HREF_OFS, 32'h0003_1234);
    upd(2'h0);
    rdchk(EVT_POS_OFS, 32'h0003_1234);
    endt("host source");
    // Both edges from the feedback location, 16 units per turn
    op(OP_DISABLE, 4'h0, ST_OK);
    cfg(4'h0, 2'h1, 2'h0, 3'h7, 32'h0000_0010, ST_OK);
    op(OP_ENABLE, 4'h0, ST_OK);
    upd(2'h1);
    k1 = upd_k;
    upd(2'h0);
    rdchk(EVT_WID_OFS, 32'h0000_0001);
    rdchk(EVT_POS_OFS, k1 + 32'h0000_0020);
    endt("both edges");
    // Negative manual pulse two updates wide
    op(OP_DISABLE, 4'h0, ST_OK);
    cfg(4'h0, 2'h1, 2'h0, 3'h1, 32'h0000_0010, ST_OK);
    op(OP_ENABLE, 4'h0, ST_OK);
    upd(2'h1);
    k1 = upd_k;
    upd(2'h0);
    upd(2'h0);
    upd(2'h1);
    rdchk(CAPSTAT_OFS, 32'h0000_0001);
    rdchk(EVT_WID_OFS, 32'h0000_0002);
    rdchk(EVT_POS_OFS, k1 + 32'h0000_0020);
    endt("negative pulse");
    give_verdict();
  end
endmodule
`default_nettype wire
